// ===== core_model.sv
// processor core model issuing register and external move accesses
`timescale 1ns/100ps
module core_model
  import flash_lock_pkg::*;
#(
  parameter int ADDR_W = 16  // move address width
)
(
  // clock
  input  wire logic         clk_sys_in,
  // register access
  output logic              sfr_wr_out,
  output logic              sfr_rd_out,
  output logic [7:0]        sfr_addr_out,
  output logic [7:0]        sfr_wdata_out,
  input  wire logic [7:0]   sfr_rdata_in,
  // external move writes
  output logic              xmove_wr_out,
  output logic [ADDR_W-1:0] xmove_addr_out,
  output logic [7:0]        xmove_wdata_out
);
  // ---------------------------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------------------------
  initial begin
    {sfr_wr_out, sfr_rd_out, xmove_wr_out} = 3'h0;
    {sfr_addr_out, sfr_wdata_out, xmove_wdata_out} = 24'h0;
    xmove_addr_out = '0;
  end

  // ---------------------------------------------------------------
  // bus cycles: drive after an edge, hold one edge, then release
  // ---------------------------------------------------------------
  // released lines show the inverse so stale values never match
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1 {sfr_addr_out, sfr_wdata_out, sfr_wr_out} = {a, d, 1'h1};
    @(posedge clk_sys_in);
    #1 {sfr_addr_out, sfr_wdata_out, sfr_wr_out} = {~a, ~d, 1'h0};
  endtask

  // read data is registered, so it is valid just after the edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    #1 {sfr_addr_out, sfr_rd_out} = {a, 1'h1};
    @(posedge clk_sys_in);
    #1 {sfr_addr_out, sfr_rd_out} = {~a, 1'h0};
    d = sfr_rdata_in;
  endtask

  // move write; caller looks at the strobes right after return
  task automatic mv_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1 {xmove_addr_out, xmove_wdata_out, xmove_wr_out} = {a, d, 1'h1};
    @(posedge clk_sys_in);
    #1 {xmove_addr_out, xmove_wdata_out, xmove_wr_out} = {~a, ~d, 1'h0};
  endtask

  // key pair in order, any idle gap between the bytes
  task automatic key_pair(input int gap);
    reg_wr(KEY_OFFSET, KEY_FIRST);
    repeat (gap) @(posedge clk_sys_in);
    reg_wr(KEY_OFFSET, KEY_SECOND);
  endtask
endmodule // core_model

// ===== flash_key_fsm.sv
// key sequence state machine for the flash write lock
`timescale 1ns/100ps
module flash_key_fsm
  import flash_lock_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // key register write and flash op events
  input  wire logic       key_wr_in,
  input  wire logic [7:0] key_data_in,
  input  wire logic       op_try_in,
  // lock state
  output logic [1:0]      lock_state_out
);

  // states, no codes given
  typedef enum {ST_LOCKED, ST_HALF, ST_OPEN, ST_DEAD} key_state_type;

  key_state_type state_ff;   // present state
  key_state_type nxt_state;  // next state

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // dead is terminal, only reset leaves it
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LOCKED: begin
        if (op_try_in) begin
          nxt_state = ST_DEAD;                       // see R05
        end else if (key_wr_in) begin
          nxt_state = (key_data_in == KEY_FIRST) ? ST_HALF
                                                 : ST_DEAD; // see R02
        end
      end
      ST_HALF: begin
        // any gap between the two writes is fine
        if (op_try_in) begin
          nxt_state = ST_DEAD;                       // see R05
        end else if (key_wr_in) begin
          nxt_state = (key_data_in == KEY_SECOND) ? ST_OPEN
                                                  : ST_DEAD; // see R03
        end
      end
      ST_OPEN: begin
        // one op spends the unlock; a third key write is wrong
        if (op_try_in) begin
          nxt_state = ST_LOCKED;                     // see R04 R11
        end else if (key_wr_in) begin
          nxt_state = ST_DEAD;                       // see R05
        end
      end
      ST_DEAD:   nxt_state = ST_DEAD;                // see R05
      default:   nxt_state = ST_DEAD;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_LOCKED;                         // see R01
    end else begin
      state_ff <= nxt_state;
    end
  end

  // state to read code
  always_comb begin
    case (state_ff)
      ST_LOCKED: lock_state_out = LOCK_LOCKED;       // see R06
      ST_HALF:   lock_state_out = LOCK_HALF;
      ST_OPEN:   lock_state_out = LOCK_OPEN;
      default:   lock_state_out = LOCK_DEAD;
    endcase
  end

  // dead lock never recovers without reset
  dead_stays_a: assert property ( // see R05
    @(posedge clk_sys_in) disable iff (rst_in)
    state_ff == ST_DEAD |=> state_ff == ST_DEAD)
    else $error("disabled lock state left without reset");

  // one op after unlock relocks
  op_relocks_a: assert property ( // see R04
    @(posedge clk_sys_in) disable iff (rst_in)
    state_ff == ST_OPEN && op_try_in |=> state_ff == ST_LOCKED)
    else $error("unlock was not spent by one operation");

endmodule // flash_key_fsm

// ===== flash_lock_pkg.sv
// constants shared by the flash write lock control block
package flash_lock_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SCALE_OFFSET   = 8'hB6; // timing scale
  localparam logic [7:0] KEY_OFFSET     = 8'hB7; // unlock key
  localparam logic [7:0] STORE_OFFSET   = 8'h8F; // store control

  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] SCALE_RESET    = 8'h80; // one-shot on
  localparam logic [7:0] KEY_RESET      = 8'h00; // locked
  localparam logic [7:0] STORE_RESET    = 8'h00; // writes off
  localparam int         ONESHOT_BIT    = 7;     // scale bit 7
  localparam int         WRITE_EN_BIT   = 0;     // store bit 0
  localparam int         ERASE_EN_BIT   = 1;     // store bit 1

  // ---------------------------------------------------------------
  // key codes and lock state encoding
  // ---------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST      = 8'hA5; // first key byte
  localparam logic [7:0] KEY_SECOND     = 8'hF1; // second key byte
  localparam logic [1:0] LOCK_LOCKED    = 2'h0;  // read code 00
  localparam logic [1:0] LOCK_HALF      = 2'h1;  // read code 01
  localparam logic [1:0] LOCK_OPEN      = 2'h2;  // read code 10
  localparam logic [1:0] LOCK_DEAD      = 2'h3;  // read code 11

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 40;    // system clock period
  localparam int         SENSE_FULL_NS  = 40;    // one full cycle
  localparam int         SENSE_CYCLES   =
    (SENSE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== flash_write_lock_control.sv
// flash write lock control: key gate, store control and read one-shot
//
// What this block does
// R01: flash writes stay locked until key written
// R02: software writes 0xA5 then 0xF1 to unlock
// R03: any gap allowed between the two keys
// R04: one unlock permits exactly one operation
// R05: wrong key or early op disables until reset
// R06: key read shows lock state in bits 1:0
// R07: scale bit 7 enables read one-shot, resets set
// R08: one-shot off keeps sense amps on whole cycle
// R09: write enable sends moves to flash bytes
// R10: erase plus write enable erases whole page
// R11: lock returns to locked after each operation
`timescale 1ns/100ps
module flash_write_lock_control
  import flash_lock_pkg::*;
#(
  parameter int ADDR_W = 16  // external move address width
)
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // special register access from the core
  input  wire logic              sfr_wr_in,
  input  wire logic              sfr_rd_in,
  input  wire logic [7:0]        sfr_addr_in,
  input  wire logic [7:0]        sfr_wdata_in,
  output logic [7:0]             sfr_rdata_out,
  // external move writes from the core
  input  wire logic              xmove_wr_in,
  input  wire logic [ADDR_W-1:0] xmove_addr_in,
  input  wire logic [7:0]        xmove_wdata_in,
  // flash array side
  output logic                   flash_write_out,
  output logic                   flash_erase_out,
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic [7:0]             flash_wdata_out,
  output logic                   xram_write_out,
  // read path sense amp control
  input  wire logic              flash_read_in,
  output logic                   sense_full_out,
  output logic                   oneshot_en_out
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire        hit_scale = sfr_addr_in == SCALE_OFFSET;  // scale reg
  wire        hit_key   = sfr_addr_in == KEY_OFFSET;    // key reg
  wire        hit_store = sfr_addr_in == STORE_OFFSET;  // store ctrl
  wire        wr_scale  = sfr_wr_in && hit_scale;
  wire        wr_key    = sfr_wr_in && hit_key;
  wire        wr_store  = sfr_wr_in && hit_store;

  logic [7:0] scale_ff;      // timing scale register
  logic [7:0] store_ff;      // program store control
  logic [1:0] lock_state;    // state from key machine

  // store control enables
  wire        write_en  = store_ff[WRITE_EN_BIT];
  wire        erase_en  = store_ff[ERASE_EN_BIT];
  wire        to_flash  = xmove_wr_in && write_en;      // see R09
  // only an open lock lets the operation through
  wire        allowed   = lock_state == LOCK_OPEN;       // see R01
  wire        do_write  = to_flash && allowed && !erase_en; // see R09
  wire        do_erase  = to_flash && allowed && erase_en;  // see R10

  // ---------------------------------------------------------------
  // key sequence machine
  // ---------------------------------------------------------------
  flash_key_fsm u_key (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .key_wr_in      (wr_key),
    .key_data_in    (sfr_wdata_in),
    .op_try_in      (to_flash),                          // see R04 R05
    .lock_state_out (lock_state)
  );

  // ---------------------------------------------------------------
  // registers written by software
  // ---------------------------------------------------------------
  // reserved scale bits are kept as zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      scale_ff <= SCALE_RESET;                           // see R07
      store_ff <= STORE_RESET;
    end else begin
      if (wr_scale) begin
        scale_ff <= {sfr_wdata_in[ONESHOT_BIT], 7'h00};  // see R07
      end
      if (wr_store) begin
        store_ff <= {6'h00, sfr_wdata_in[1:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // read data mux, registered
  // ---------------------------------------------------------------
  wire [7:0] rd_mux = hit_scale ? scale_ff :
                      hit_key   ? {6'h00, lock_state} :  // see R06
                      hit_store ? store_ff : 8'h00;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // flash operation strobes
  // ---------------------------------------------------------------
  // page erase ignores data; blocked ops are dropped silently
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flash_write_out <= 1'b0;
      flash_erase_out <= 1'b0;
      xram_write_out  <= 1'b0;
      flash_addr_out  <= '0;
      flash_wdata_out <= 8'h00;
    end else begin
      flash_write_out <= do_write;                       // see R09
      flash_erase_out <= do_erase;                       // see R10
      xram_write_out  <= xmove_wr_in && !write_en;
      if (to_flash) begin
        flash_addr_out  <= xmove_addr_in;
        flash_wdata_out <= erase_en ? 8'h00 : xmove_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // sense amp control
  // ---------------------------------------------------------------
  // full-cycle sensing costs power at slow clocks
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sense_full_out <= 1'b0;
      oneshot_en_out <= 1'b1;
    end else begin
      oneshot_en_out <= scale_ff[ONESHOT_BIT];           // see R07
      sense_full_out <= flash_read_in && !scale_ff[ONESHOT_BIT]; // see R08
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // first key byte taken while locked, no flash move in the same cycle
  sequence first_key_s;
    wr_key && sfr_wdata_in == KEY_FIRST && lock_state == LOCK_LOCKED
    && !to_flash;
  endsequence

  // second key byte after the first; the gap is not bounded, so the
  // half-open state stands for everything that came before
  sequence second_key_s;
    wr_key && sfr_wdata_in == KEY_SECOND && lock_state == LOCK_HALF
    && !to_flash;
  endsequence

  // first key moves the lock to half open
  key_half_a: assert property ( // see R02
    @(posedge clk_sys_in) disable iff (rst_in)
    first_key_s |=> lock_state == LOCK_HALF)
    else $error("first key did not advance the lock");

  // second key opens the lock after any gap
  key_unlocks_a: assert property ( // see R03
    @(posedge clk_sys_in) disable iff (rst_in)
    second_key_s |=> lock_state == LOCK_OPEN)
    else $error("correct key pair did not unlock");

  // a closed lock lets no strobe through
  locked_no_write_a: assert property ( // see R01
    @(posedge clk_sys_in) disable iff (rst_in)
    to_flash && lock_state != LOCK_OPEN
    |=> !flash_write_out && !flash_erase_out)
    else $error("flash operation passed a closed lock");

  // wrong first byte kills the lock
  bad_key_dead_a: assert property ( // see R05
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_key && lock_state == LOCK_LOCKED && sfr_wdata_in != KEY_FIRST
    && !to_flash |=> lock_state == LOCK_DEAD)
    else $error("wrong key did not disable flash");

  // key read returns the state seen at the read edge
  key_readback_a: assert property ( // see R06
    @(posedge clk_sys_in) disable iff (rst_in)
    sfr_rd_in && hit_key
    |=> sfr_rdata_out == {6'h00, $past(lock_state)})
    else $error("key read does not show lock state");

  // one-shot enable output follows scale bit 7
  oneshot_copy_a: assert property ( // see R07
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_scale |=> ##1 oneshot_en_out == $past(sfr_wdata_in[ONESHOT_BIT], 2))
    else $error("one-shot enable does not follow scale bit");

  // both enables with an open lock give a page erase
  erase_page_a: assert property ( // see R10
    @(posedge clk_sys_in) disable iff (rst_in)
    xmove_wr_in && write_en && erase_en && allowed
    |=> flash_erase_out && !flash_write_out)
    else $error("erase request did not erase");

  // byte write carries the move data
  write_byte_a: assert property ( // see R09
    @(posedge clk_sys_in) disable iff (rst_in)
    do_write
    |=> flash_write_out && flash_wdata_out == $past(xmove_wdata_in))
    else $error("byte write lost or wrong data");

  // write enable clear keeps moves in ram
  xram_route_a: assert property ( // see R09
    @(posedge clk_sys_in) disable iff (rst_in)
    xmove_wr_in && !write_en
    |=> xram_write_out && !flash_write_out && !flash_erase_out)
    else $error("ram move reached the flash side");

  // a spent unlock drops back to locked
  op_relock_a: assert property ( // see R11
    @(posedge clk_sys_in) disable iff (rst_in)
    to_flash && allowed |=> lock_state == LOCK_LOCKED)
    else $error("lock not restored after operation");

  // one-shot off holds the amps for the whole read cycle
  sense_full_a: assert property ( // see R08
    @(posedge clk_sys_in) disable iff (rst_in)
    flash_read_in && !scale_ff[ONESHOT_BIT] |=> sense_full_out)
    else $error("sense amps not held for full cycle");

endmodule // flash_write_lock_control

// ===== tb_top.sv
// self-checking testbench for the flash write lock control block
`timescale 1ns/100ps
module tb_top;
  import flash_lock_pkg::*;
  // ---------------------------------------------------------------
  // wiring
  // ---------------------------------------------------------------
  logic        clk_sys_in, rst_in, flash_read;  // bench driven
  logic        sfr_wr, sfr_rd, xmove_wr;        // core strobes
  logic        flash_write, flash_erase, xram_write;
  logic        sense_full, oneshot_en;          // read path
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xmove_wdata, flash_wdata;
  logic [15:0] xmove_addr, flash_addr;
  logic [7:0]  r;                               // read result
  int          err_total, compares;

  core_model core_u (.clk_sys_in(clk_sys_in), .sfr_wr_out(sfr_wr),
    .sfr_rd_out(sfr_rd), .sfr_addr_out(sfr_addr),
    .sfr_wdata_out(sfr_wdata), .sfr_rdata_in(sfr_rdata),
    .xmove_wr_out(xmove_wr), .xmove_addr_out(xmove_addr),
    .xmove_wdata_out(xmove_wdata));

  flash_write_lock_control dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_addr_in(sfr_addr),
    .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata),
    .xmove_wr_in(xmove_wr), .xmove_addr_in(xmove_addr),
    .xmove_wdata_in(xmove_wdata), .flash_write_out(flash_write),
    .flash_erase_out(flash_erase), .flash_addr_out(flash_addr),
    .flash_wdata_out(flash_wdata), .xram_write_out(xram_write),
    .flash_read_in(flash_read), .sense_full_out(sense_full),
    .oneshot_en_out(oneshot_en));

  // ---------------------------------------------------------------
  // clock, compare, verdict
  // ---------------------------------------------------------------
  initial begin
    clk_sys_in = 1'h0;
    forever #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
  end

  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // expected read of the scale register: only bit 7 is kept
  function automatic logic [7:0] scale_exp(logic [7:0] w);
    return {w[ONESHOT_BIT], 7'h00};
  endfunction

  // reset held two edges, released just after an edge
  task automatic do_reset();
    rst_in = 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1 rst_in = 1'h0;
  endtask

  // one sense-amp read with the expected full-cycle flag
  task automatic read_pulse(input logic e);
    @(posedge clk_sys_in);
    #1 flash_read = 1'h1;
    @(posedge clk_sys_in);
    #1 flash_read = 1'h0;
    check("sense full", e, sense_full);
  endtask

  // unlock, one store write or page erase, then lock again
  task automatic flash_op(input logic er);
    logic [15:0] a;
    logic [7:0]  d;
    a = 16'($urandom);
    d = 8'($urandom);
    core_u.reg_wr(STORE_OFFSET, {6'h00, er, 1'h1});
    core_u.key_pair($urandom_range(0, 40));
    core_u.reg_rd(KEY_OFFSET, r);
    check("key open", LOCK_OPEN, r);
    core_u.mv_wr(a, d);
    check("write strobe", !er, flash_write);
    check("erase strobe", er, flash_erase);
    check("flash addr", a, flash_addr);
    check("flash data", er ? 8'h00 : d, flash_wdata);
    core_u.reg_rd(KEY_OFFSET, r);
    check("relock", LOCK_LOCKED, r);
  endtask

  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    finish_test();
  end

  initial begin
    {err_total, compares} = '0;
    flash_read = 1'h0;
    void'($urandom(18820));
    do_reset();
    core_u.reg_rd(SCALE_OFFSET, r);
    check("scale reset", SCALE_RESET, r);
    check("oneshot reset", 1'h1, oneshot_en);
    core_u.reg_rd(KEY_OFFSET, r);
    check("key reset", KEY_RESET, r);
    core_u.reg_rd(8'h3C, r);
    check("unmapped", 8'h00, r);
    core_u.mv_wr(16'h1234, 8'h5A);
    check("xram move", 1'h1, xram_write);
    check("no flash", 1'h0, flash_write);
    core_u.reg_wr(KEY_OFFSET, KEY_FIRST);
    core_u.reg_rd(KEY_OFFSET, r);
    check("key half", LOCK_HALF, r);
    do_reset();
    for (int i = 0; i < 8; i++) flash_op(i[0]);
    core_u.mv_wr(16'($urandom), 8'($urandom));
    check("second op", 1'h0, flash_write);
    core_u.reg_rd(KEY_OFFSET, r);
    check("dead after op", LOCK_DEAD, r);
    do_reset();
    core_u.reg_wr(KEY_OFFSET, KEY_FIRST);
    core_u.reg_wr(KEY_OFFSET, 8'($urandom_range(0, 240)));
    core_u.key_pair(1);
    core_u.reg_rd(KEY_OFFSET, r);
    check("wrong key", LOCK_DEAD, r);
    do_reset();
    core_u.reg_wr(KEY_OFFSET, KEY_SECOND);
    core_u.reg_rd(KEY_OFFSET, r);
    check("bad first key", LOCK_DEAD, r);
    do_reset();
    core_u.reg_wr(STORE_OFFSET, 8'h01);
    core_u.mv_wr(16'h00F0, 8'hC3);
    check("early op", 1'h0, flash_write);
    core_u.reg_rd(KEY_OFFSET, r);
    check("early dead", LOCK_DEAD, r);
    r = 8'($urandom) & 8'h7F;
    core_u.reg_wr(SCALE_OFFSET, r);
    core_u.reg_rd(SCALE_OFFSET, r);
    check("scale off", scale_exp(8'h00), r);
    check("oneshot off", 1'h0, oneshot_en);
    read_pulse(1'h1);
    core_u.reg_wr(SCALE_OFFSET, 8'hFF);
    core_u.reg_rd(SCALE_OFFSET, r);
    check("scale on", scale_exp(8'hFF), r);
    check("oneshot on", 1'h1, oneshot_en);
    read_pulse(1'h0);
    finish_test();
  end
endmodule // tb_top
